// *** rtl/component_resizer.sv ***
// Component processing stage: luma/chroma split, filter, resize, skew, FIFO, adjustments.
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
// Overview of operation
// - Split 4:2:2 input into separate luma and chroma processing paths.
// - Luma lowpass follows scaled pixel count, then peaking and coring.
// - Resize and skew alter line sampling rate and correct horizontal skew.
// - Pixels per line programmable 32 to 864 in steps of two.
// - Four lowpass strengths, picked by the top two bits of the 9-bit filter index, span all scaling factors.
// - Active filter chosen from pixels per line without software selection.
// - Resized samples leave through a FIFO in continuous fixed-rate bursts.
// - Luma gets contrast gain and brightness offset, then noise shaping.
// - Optional Cb/Cr swap; unswapped, first output chroma sample is Cb.
// - Vertical size reduction is done by dropping lines.
// - Luma skew interpolates linearly 0 to 31/32 pixel in 1/32 steps.
// - Chroma skew shifts 0 to 7/8 sample in 1/8 steps.
// - Luma back to 8 bits by round, truncate, 1-bit or 2-bit diffusion.
// - Coring removes 0, 1/2, 1 or 2 LSBs from high-frequency part.
module component_resizer #(
    parameter int FIFO_DEPTH = resizer_pkg::FIFO_DEPTH_DEF,
    parameter int BURST = resizer_pkg::BURST_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] luma_i,
    input wire logic [7:0] chroma_i,
    input wire logic valid_i,
    input wire logic line_start_i,
    input wire logic field_start_i,
    output logic [7:0] luma_o,
    output logic [7:0] chroma_o,
    output logic valid_o,
    output logic line_start_o
);
    import resizer_pkg::*;

    localparam int AW = $clog2(FIFO_DEPTH);

    function automatic logic [7:0] clip_luma(input logic signed [11:0] v, input logic [7:0] lo);
        if (v < $signed({4'h0, lo}))
            clip_luma = lo;
        else if (v > $signed({4'h0, LUMA_TOP}))
            clip_luma = LUMA_TOP;
        else
            clip_luma = v[7:0];
    endfunction : clip_luma

    function automatic logic [7:0] lerp8(input logic [7:0] a, input logic [7:0] b, input logic [4:0] ph);
        logic signed [14:0] d;
        d = ($signed({7'h00, b}) - $signed({7'h00, a})) * $signed({10'h000, ph});
        lerp8 = 8'(a + 8'(d >>> 5));
    endfunction : lerp8

    // ****************************************
    // Register file
    // ****************************************
    logic [9:0] ppl_r, ppl_act_r;
    logic [5:0] contrast_r;
    logic clamp32_r, swap_r, ovf_r;
    logic [7:0] bright_r;
    logic [1:0] shape_r, core_r;
    logic [2:0] peak_r, cskew_r;
    logic [4:0] yskew_r;
    logic [3:0] vdrop_r;
    logic [AW:0] count_r;

    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_req && wb_we_i;
    wire wr_size = wb_wr && wb_adr_i == ADDR_SIZE && wb_sel_i[1] && wb_sel_i[0];
    wire wr_adj = wb_wr && wb_adr_i == ADDR_ADJUST;
    wire wr_flt = wb_wr && wb_adr_i == ADDR_FILTER;
    wire wr_vdrop = wb_wr && wb_adr_i == ADDR_VDROP && wb_sel_i[0];
    wire clr_ovf = wb_wr && wb_adr_i == ADDR_STATUS && wb_sel_i[2] && wb_dat_i[STS_OVF_BIT];
    // Odd requests are forced even and out-of-range ones are held at the limit
    wire [9:0] ppl_even = {wb_dat_i[9:1], 1'b0};
    wire [9:0] ppl_wr = (ppl_even < PPL_MIN) ? PPL_MIN : (ppl_even > PPL_MAX) ? PPL_MAX : ppl_even;
    wire [31:0] rd_data =
        (wb_adr_i == ADDR_SIZE) ? {22'h000000, ppl_r} :
        (wb_adr_i == ADDR_ADJUST) ? {6'h00, shape_r, bright_r, 7'h00, clamp32_r, 2'h0, contrast_r} :
        (wb_adr_i == ADDR_FILTER) ? {7'h00, swap_r, 5'h00, cskew_r, 3'h0, yskew_r, 2'h0, core_r, 1'b0, peak_r} :
        (wb_adr_i == ADDR_VDROP) ? {28'h0000000, vdrop_r} :
        (wb_adr_i == ADDR_STATUS) ? ({15'h0000, ovf_r, 6'h00, ppl_act_r} | (32'(count_r) << 20)) :
        32'h00000000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ppl_r <= PPL_RESET;
            contrast_r <= CONTRAST_RESET;
            clamp32_r <= 1'b0;
            bright_r <= BRIGHT_RESET;
            shape_r <= 2'h0;
            core_r <= 2'h0;
            peak_r <= 3'h0;
            yskew_r <= 5'h00;
            cskew_r <= 3'h0;
            swap_r <= 1'b0;
            vdrop_r <= 4'h0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_data : 32'h00000000;
            if (wr_size)
                ppl_r <= ppl_wr;
            if (wr_adj && wb_sel_i[0])
                contrast_r <= wb_dat_i[ADJ_CONTRAST_LSB +: 6];
            if (wr_adj && wb_sel_i[1])
                clamp32_r <= wb_dat_i[ADJ_CLAMP_BIT];
            if (wr_adj && wb_sel_i[2])
                bright_r <= wb_dat_i[ADJ_BRIGHT_LSB +: 8];
            if (wr_adj && wb_sel_i[3])
                shape_r <= wb_dat_i[ADJ_SHAPE_LSB +: 2];
            if (wr_flt && wb_sel_i[0])
            begin
                peak_r <= wb_dat_i[FLT_PEAK_LSB +: 3];
                core_r <= wb_dat_i[FLT_CORE_LSB +: 2];
            end
            if (wr_flt && wb_sel_i[1])
                yskew_r <= wb_dat_i[FLT_YSKEW_LSB +: 5];
            if (wr_flt && wb_sel_i[2])
                cskew_r <= wb_dat_i[FLT_CSKEW_LSB +: 3];
            if (wr_flt && wb_sel_i[3])
                swap_r <= wb_dat_i[FLT_SWAP_BIT];
            if (wr_vdrop)
                vdrop_r <= wb_dat_i[3:0];
        end
    end

    // ****************************************
    // Input split and line dropping
    // ****************************************
    logic [3:0] line_cnt_r;
    logic keep_r, cphase_r;
    logic [7:0] y0_r, y1_r, cb0_r, cb1_r, cr0_r, cr1_r;
    logic in_vld_r;
    wire keep_line = (line_cnt_r == vdrop_r);
    wire in_take = valid_i && keep_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            line_cnt_r <= 4'h0;
            keep_r <= 1'b0;
            cphase_r <= 1'b0;
            ppl_act_r <= PPL_RESET;
            in_vld_r <= 1'b0;
            {y0_r, y1_r, cb0_r, cb1_r, cr0_r, cr1_r} <= 48'h000000000000;
        end
        else
        begin
            in_vld_r <= in_take;
            if (field_start_i)
                line_cnt_r <= 4'h0;
            else if (line_start_i)
            begin
                line_cnt_r <= keep_line ? 4'h0 : 4'(line_cnt_r + 4'h1);
                keep_r <= keep_line;
                ppl_act_r <= ppl_r;
                cphase_r <= 1'b0;
            end
            if (in_take)
            begin
                y1_r <= y0_r;
                y0_r <= luma_i;
                cphase_r <= !cphase_r;
                if (!cphase_r)
                    {cb1_r, cb0_r} <= {cb0_r, chroma_i};
                else
                    {cr1_r, cr0_r} <= {cr0_r, chroma_i};
            end
        end
    end

    // ****************************************
    // Luma filter: lowpass, peaking, coring
    // ****************************************
    // Filter index: ppl/2, whose top two bits pick one of four lowpass strengths; narrow sizes get strong smoothing
    wire [8:0] filter_sel = ppl_act_r[9:1];
    wire [1:0] aa_k = 2'h3 - filter_sel[8:7];
    wire [7:0] y_aa = lerp8(y0_r, y1_r, {1'b0, aa_k, 2'h0});
    wire signed [9:0] hf = $signed({2'h0, y0_r}) - $signed({2'h0, y_aa});
    wire [9:0] hf_mag = hf[9] ? 10'(-hf) : 10'(hf);
    wire [10:0] core_amt = (core_r == CORE_NONE) ? 11'h000 : (core_r == CORE_HALF) ? 11'h001 :
                           (core_r == CORE_ONE) ? 11'h002 : 11'h004;
    wire [10:0] hf_x2 = {hf_mag, 1'b0};
    wire [10:0] cored = (hf_x2 > core_amt) ? 11'(hf_x2 - core_amt) : 11'h000;
    wire signed [13:0] peak_add = $signed({1'b0, 13'(({2'h0, cored} * {10'h000, peak_r}) >> 4)});
    wire signed [13:0] peak_sgn = hf[9] ? -peak_add : peak_add;
    wire signed [13:0] y_pk = $signed({6'h00, y_aa}) + peak_sgn;
    wire [7:0] y_filt = (y_pk < 0) ? 8'h00 : (y_pk > 14'sd255) ? 8'hff : y_pk[7:0];

    // ****************************************
    // Resize with skew as initial phase offset
    // ****************************************
    logic [10:0] acc_r;
    logic [7:0] yf_prev_r;
    // Skew stays below one output pixel so it never adds a sample to the line
    wire [10:0] skew_init = 11'((({11'h000, yskew_r} * {5'h00, IN_SAMPLES}) + 16'h001f) >> 5);
    wire [11:0] acc_sum = {1'b0, acc_r} + {2'h0, ppl_act_r};
    wire emit = in_vld_r && acc_sum >= {1'b0, IN_SAMPLES};
    wire [10:0] acc_nxt = emit ? 11'(acc_sum - {1'b0, IN_SAMPLES}) : acc_sum[10:0];
    wire [15:0] phase_num = {acc_nxt, 5'h00};
    wire [4:0] phase = 5'(phase_num / {5'h00, IN_SAMPLES});
    wire [7:0] y_rs = lerp8(yf_prev_r, y_filt, phase);
    wire [7:0] cb_rs = lerp8(cb1_r, cb0_r, {cskew_r, 2'h0});
    wire [7:0] cr_rs = lerp8(cr1_r, cr0_r, {cskew_r, 2'h0});

    // ****************************************
    // Contrast, brightness, noise shaping
    // ****************************************
    // Fourteen-bit signed result carries two fraction bits for the shaping step
    logic [1:0] err_r;
    wire [13:0] prod = {6'h00, y_rs} * {8'h00, contrast_r};
    wire signed [13:0] y10 = $signed({1'b0, 13'(prod >> 3)}) + $signed({{4{bright_r[7]}}, bright_r, 2'h0});
    wire [1:0] frac = y10[1:0];
    wire [2:0] fr_e1 = {1'b0, frac} + {2'h0, err_r[1]};
    wire [2:0] fr_e2 = {1'b0, frac} + {1'b0, err_r};
    wire rnd_up = (shape_r == SHAPE_ROUND) ? frac[1] : (shape_r == SHAPE_TRUNC) ? 1'b0 :
                  (shape_r == SHAPE_DIFF1) ? fr_e1[2] : fr_e2[2];
    wire [1:0] err_nxt = (shape_r == SHAPE_DIFF1) ? {fr_e1[1], 1'b0} :
                         (shape_r == SHAPE_DIFF2) ? fr_e2[1:0] : 2'h0;
    wire signed [11:0] y8 = 12'(y10 >>> 2) + $signed({11'h000, rnd_up});
    wire [7:0] y_out = clip_luma(y8, clamp32_r ? CLAMP_LO32 : CLAMP_LO16);

    // ****************************************
    // Chroma ordering and FIFO
    // ****************************************
    logic out_cphase_r;
    logic line_pend_r;
    logic [15:0] mem [FIFO_DEPTH];
    logic [AW-1:0] wp_r, rp_r;
    logic burst_r;
    wire [7:0] c_sel = (out_cphase_r ^ swap_r) ? cr_rs : cb_rs;
    wire fifo_full = count_r == (AW+1)'(FIFO_DEPTH);
    wire fifo_empty = count_r == '0;
    wire fifo_wr = emit && !fifo_full;
    wire fifo_rd = burst_r && !fifo_empty;
    wire burst_go = count_r >= (AW+1)'(BURST) || (line_pend_r && !fifo_empty);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc_r <= 11'h000;
            yf_prev_r <= 8'h00;
            err_r <= 2'h0;
            out_cphase_r <= 1'b0;
            line_pend_r <= 1'b0;
            wp_r <= '0;
            rp_r <= '0;
            count_r <= '0;
            burst_r <= 1'b0;
            ovf_r <= 1'b0;
            luma_o <= 8'h00;
            chroma_o <= 8'h00;
            valid_o <= 1'b0;
            line_start_o <= 1'b0;
        end
        else
        begin
            if (line_start_i)
            begin
                acc_r <= skew_init;
                out_cphase_r <= 1'b0;
                err_r <= 2'h0;
            end
            else
            begin
                if (in_vld_r)
                    {acc_r, yf_prev_r} <= {acc_nxt, y_filt};
                if (emit)
                    {out_cphase_r, err_r} <= {!out_cphase_r, err_nxt};
            end
            // Flush a line's tail once its last sample is in, and keep flushing a tail still queued at the next line start
            line_pend_r <= (in_vld_r && !in_take) || ((line_start_i || line_pend_r) && !fifo_empty);
            if (fifo_wr)
            begin
                mem[wp_r] <= {y_out, c_sel};
                wp_r <= AW'(wp_r + 1'b1);
            end
            if (fifo_rd)
                rp_r <= AW'(rp_r + 1'b1);
            count_r <= (AW+1)'(count_r + (AW+1)'(fifo_wr) - (AW+1)'(fifo_rd));
            // A burst runs until the FIFO drains so output samples stay back to back
            burst_r <= burst_r ? !(fifo_empty || (count_r == (AW+1)'(1) && fifo_rd && !fifo_wr)) : burst_go;
            ovf_r <= (emit && fifo_full) || (ovf_r && !clr_ovf);
            valid_o <= fifo_rd;
            luma_o <= fifo_rd ? mem[rp_r][15:8] : 8'h00;
            chroma_o <= fifo_rd ? mem[rp_r][7:0] : 8'h00;
            line_start_o <= line_start_i && keep_line;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_line_edge;
        line_start_i && !field_start_i;
    endsequence

    a_ppl_range: assert property (@(posedge clk_i) disable iff (rst_i)
        ppl_r >= PPL_MIN && ppl_r <= PPL_MAX && !ppl_r[0]) else $error("pixel count out of range");
    a_ppl_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(line_start_i) |-> $stable(ppl_act_r)) else $error("pixel count changed mid line");
    a_ppl_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_line_edge |=> ppl_act_r == $past(ppl_r)) else $error("pixel count not loaded at line start");
    a_emit_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        emit |-> in_vld_r && acc_nxt < IN_SAMPLES) else $error("resize accumulator overrun");
    a_fifo_order: assert property (@(posedge clk_i) disable iff (rst_i)
        fifo_rd |=> valid_o) else $error("FIFO read not presented");
    a_fifo_level: assert property (@(posedge clk_i) disable iff (rst_i)
        count_r <= (AW+1)'(FIFO_DEPTH)) else $error("FIFO level beyond depth");
    a_luma_clip: assert property (@(posedge clk_i) disable iff (rst_i)
        valid_o |-> luma_o <= LUMA_TOP && luma_o >= CLAMP_LO16) else $error("luma outside legal range");
    a_cb_first: assert property (@(posedge clk_i) disable iff (rst_i)
        s_line_edge ##1 (!emit)[*1] |-> !out_cphase_r) else $error("line does not start with Cb");
    a_drop_line: assert property (@(posedge clk_i) disable iff (rst_i)
        line_start_i && !keep_line && !field_start_i |=> !keep_r) else $error("dropped line kept");
    a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wb_req |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack not one cycle");
endmodule : component_resizer

// *** rtl/resizer_pkg.sv ***
// Constants shared by the component resizer: register map, fields, reset values, limits.
package resizer_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_SIZE = 8'h00;
    localparam logic [7:0] ADDR_ADJUST = 8'h04;
    localparam logic [7:0] ADDR_FILTER = 8'h08;
    localparam logic [7:0] ADDR_VDROP = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int ADJ_CONTRAST_LSB = 0;
    localparam int ADJ_CLAMP_BIT = 8;
    localparam int ADJ_BRIGHT_LSB = 16;
    localparam int ADJ_SHAPE_LSB = 24;
    localparam int FLT_PEAK_LSB = 0;
    localparam int FLT_CORE_LSB = 4;
    localparam int FLT_YSKEW_LSB = 8;
    localparam int FLT_CSKEW_LSB = 16;
    localparam int FLT_SWAP_BIT = 24;
    localparam int STS_OVF_BIT = 16;
    // ****************************************
    // Reset values and limits
    // ****************************************
    localparam logic [9:0] PPL_MIN = 10'h020;
    localparam logic [9:0] PPL_MAX = 10'h360;
    localparam logic [9:0] PPL_RESET = 10'h2d0;
    localparam logic [10:0] IN_SAMPLES = 11'h438;
    localparam logic [5:0] CONTRAST_RESET = 6'h20;
    localparam logic [7:0] BRIGHT_RESET = 8'h00;
    localparam logic [7:0] LUMA_TOP = 8'heb;
    localparam logic [7:0] CLAMP_LO16 = 8'h10;
    localparam logic [7:0] CLAMP_LO32 = 8'h20;
    localparam int FILTER_COUNT = 512;
    localparam int FIFO_DEPTH_DEF = 64;
    localparam int BURST_DEF = 16;
    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [1:0] {SHAPE_ROUND, SHAPE_TRUNC, SHAPE_DIFF1, SHAPE_DIFF2} shape_t;
    typedef enum logic [1:0] {CORE_NONE, CORE_HALF, CORE_ONE, CORE_TWO} core_t;
endpackage : resizer_pkg

// *** verification/video_source.sv ***
// Behavioural colour-decoder source that feeds whole 4:2:2 lines into the resizer.
`timescale 1ns/10ps
module video_source (
    input wire logic clk_i,
    output logic [7:0] luma_o,
    output logic [7:0] chroma_o,
    output logic valid_o,
    output logic line_start_o,
    output logic field_start_o
);
    initial
    begin
        luma_o = 8'h00;
        chroma_o = 8'h00;
        valid_o = 1'b0;
        line_start_o = 1'b0;
        field_start_o = 1'b0;
    end
    // ****************************************
    // Line generator
    // ****************************************
    // Idle data shows the inverse of the last value, so stale samples never pass for valid ones
    task automatic send_line(input logic [7:0] y, input logic [7:0] cb, input logic [7:0] cr, input bit fs);
        int i;
        if (fs)
        begin
            @(posedge clk_i);
            field_start_o <= 1'b1;
        end
        @(posedge clk_i);
        field_start_o <= 1'b0;
        line_start_o <= 1'b1;
        for (i = 0; i < 1080; i++)
        begin
            @(posedge clk_i);
            line_start_o <= 1'b0;
            valid_o <= 1'b1;
            luma_o <= y;
            chroma_o <= i[0] ? cr : cb;
        end
        @(posedge clk_i);
        valid_o <= 1'b0;
        luma_o <= ~y;
        chroma_o <= ~cr;
    endtask : send_line
endmodule : video_source

// *** verification/component_resizer_tb.sv ***
// Self-checking testbench for the component resizer: register access and line processing.
`timescale 1ns/10ps
module component_resizer_tb;
    import resizer_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [7:0] luma_i;
    logic [7:0] chroma_i;
    logic valid_i;
    logic line_start_i;
    logic field_start_i;
    logic [7:0] luma_o;
    logic [7:0] chroma_o;
    logic valid_o;
    logic line_start_o;
    int fail_count = 0;
    int n_compared = 0;
    int n_out = 0;
    int n_lines = 0;
    int l0;
    int k;
    logic [7:0] first_c;
    logic [7:0] mid_y;
    localparam logic [31:0] sz_in [5] = '{32'h10, 32'h3ff, 32'h65, 32'h100, 32'h40};
    localparam logic [3:0] sz_sel [5] = '{4'hf, 4'hf, 4'hf, 4'hc, 4'hf};
    localparam logic [31:0] sz_exp [5] = '{32'h20, 32'h360, 32'h64, 32'h64, 32'h40};
    localparam logic [31:0] adj [7] = '{32'h28, 32'h0100003f, 32'h02810020, 32'h03810120, 32'h00100020,
        32'h2a, 32'h0100002a};
    localparam logic [7:0] y_in [7] = '{8'h80, 8'hc0, 8'h20, 8'h20, 8'h50, 8'h82, 8'h82};
    localparam logic [7:0] y_exp [7] = '{8'ha0, 8'heb, 8'h10, 8'h20, 8'h60, 8'hab, 8'haa};

    always #25 clk_i = ~clk_i;

    component_resizer #(.FIFO_DEPTH(64), .BURST(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .luma_i(luma_i), .chroma_i(chroma_i), .valid_i(valid_i),
        .line_start_i(line_start_i), .field_start_i(field_start_i), .luma_o(luma_o), .chroma_o(chroma_o),
        .valid_o(valid_o), .line_start_o(line_start_o));

    video_source src (.clk_i(clk_i), .luma_o(luma_i), .chroma_o(chroma_i), .valid_o(valid_i),
        .line_start_o(line_start_i), .field_start_o(field_start_i));

    // ****************************************
    // Output monitor
    // ****************************************
    always @(posedge clk_i)
    begin
        if (line_start_o === 1'b1)
        begin
            n_out <= 0;
            n_lines <= n_lines + 1;
        end
        else if (valid_o === 1'b1)
        begin
            if (n_out == 0)
                first_c <= chroma_o;
            // Sample well inside the line, clear of filter start-up at the edge
            if (n_out == 8)
                mid_y <= luma_o;
            n_out <= n_out + 1;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic summarize();
        $display("Comparisons: %0d, mismatches: %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : check32

    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
        output logic [31:0] rdat);
        int t;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        t = 0;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (wb_ack_o !== 1'b1 && t < 50);
        rdat = wb_dat_o;
        if (t >= 50)
            fail_count++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_cycle

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] d;
        wb_cycle(1'b1, adr, dat, sel, d);
    endtask : wr

    task automatic rd_check(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] d;
        wb_cycle(1'b0, adr, 32'h0, 4'hf, d);
        check32(d & mask, exp);
    endtask : rd_check

    // Fixed drain time covers the FIFO emptying after the last input sample
    task automatic run_line(input logic [7:0] y, input bit fs);
        src.send_line(y, 8'h30, 8'hc0, fs);
        repeat (300) @(posedge clk_i);
    endtask : run_line

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_check(ADDR_SIZE, 32'h3ff, 32'h2d0);
        rd_check(ADDR_ADJUST, 32'h03ff_01ff, 32'h20);
        rd_check(ADDR_FILTER, 32'h0107_1f37, 32'h0);
        rd_check(ADDR_VDROP, 32'hf, 32'h0);
        wr(8'h14, 32'hffff_ffff, 4'hf);
        rd_check(8'h14, 32'hffff_ffff, 32'h0);
        for (k = 0; k < 5; k++)
        begin
            wr(ADDR_SIZE, sz_in[k], sz_sel[k]);
            rd_check(ADDR_SIZE, 32'h3ff, sz_exp[k]);
        end
        rd_check(ADDR_STATUS, 32'h3ff, 32'h2d0);
        run_line(8'h80, 1'b1);
        rd_check(ADDR_STATUS, 32'hfff1_03ff, 32'h40);
        run_line(8'h80, 1'b0);
        check32(32'(n_out), 32'd64);
        check32({24'h0, first_c}, 32'h30);
        for (k = 0; k < 7; k++)
        begin
            wr(ADDR_ADJUST, adj[k], 4'hf);
            run_line(y_in[k], 1'b0);
            check32({24'h0, mid_y}, {24'h0, y_exp[k]});
        end
        wr(ADDR_ADJUST, 32'h20, 4'hf);
        wr(ADDR_FILTER, 32'h0107_1f37, 4'hf);
        rd_check(ADDR_FILTER, 32'h0107_1f37, 32'h0107_1f37);
        run_line(8'h80, 1'b0);
        check32({24'h0, mid_y}, 32'h80);
        check32({24'h0, first_c}, 32'hc0);
        wr(ADDR_VDROP, 32'h1, 4'hf);
        l0 = n_lines;
        run_line(8'h80, 1'b1);
        run_line(8'h80, 1'b0);
        check32(32'(n_lines - l0), 32'd1);
        wr(ADDR_VDROP, 32'h0, 4'hf);
        l0 = n_lines;
        run_line(8'h80, 1'b1);
        run_line(8'h80, 1'b0);
        check32(32'(n_lines - l0), 32'd2);
        rd_check(ADDR_STATUS, 32'h1_0000, 32'h0);
        summarize();
    end

    initial
    begin
        repeat (40000) @(posedge clk_i);
        fail_count++;
        summarize();
    end
endmodule : component_resizer_tb
